//--- pwm_output_stage_control.v
// pwm unit: four time bases, eight compare outputs, output conditioning
`timescale 1ns/1ps
`default_nettype none
`include "pwm_stage_map.vh"

// Overview of operation
// [R1] suppressed output goes inactive during fault
// [R2] unsuppressed outputs keep waveform during fault
// [R3] fault level defaults low, always low basic
// [R4] per-output level picks high or low
// [R5] fault level ignored for unsuppressed outputs
// [R6] selectable level only in extended variant
// [R7] invert set makes output active low
// [R8] invert clear passes output unchanged
// [R9] enable set drives generated signal
// [R10] enable clear holds output inactive
// [R11] width counted in pwm clock ticks
// [R12] width sets high part before inversion
// [R13] width read returns last programmed value
// [R14] later writes overwrite pending width
// [R15] sync command zeroes selected counters together
// [R16] generator select is per-generator bitmask
// [R17] sync update applies queued values at zero
// [R18] period is ticks between zero events
// [R19] outputs resume waveform when fault clears
module pwm_output_stage_control
#(
    parameter EXT_FAULT = 1
)
(
    input wire clk,
    input wire rst,
    input wire faultIn,
    input wire [`NUM_OUTS-1:0] output_select_mask,
    input wire cfgSuppressWrite,
    input wire fault_suppress_select,
    input wire cfgLevelWrite,
    input wire fault_level_high_select,
    input wire cfgInvertWrite,
    input wire invertSelect,
    input wire cfgEnableWrite,
    input wire enableSelect,
    input wire widthWrite,
    input wire [`OUT_IDX_W-1:0] output_index,
    input wire [`CNT_W-1:0] pulse_width_count,
    output reg [`CNT_W-1:0] widthReadData,
    input wire periodWrite,
    input wire [`CNT_W-1:0] periodData,
    input wire syncTimeBase,
    input wire syncUpdate,
    input wire [`NUM_GENS-1:0] generator_select_mask,
    output wire [`NUM_GENS-1:0] genZero,
    output reg [`NUM_GENS-1:0] genPending,
    output reg [`NUM_OUTS-1:0] pwmPins,
    output wire faultSeen
);

// ------------------------------------------------------------
// fault input synchroniser
// ------------------------------------------------------------
reg faultMeta; // first stage, read only by second
reg faultSync; // safe fault level

// two flops before any logic looks at the pin
always @(posedge clk)
begin
    if (rst)
    begin
        faultMeta <= 1'b0;
        faultSync <= 1'b0;
    end
    else
    begin
        faultMeta <= faultIn;
        faultSync <= faultMeta;
    end
end

assign faultSeen = faultSync; // live fault state

// ------------------------------------------------------------
// per-output configuration bits
// ------------------------------------------------------------
reg [`NUM_OUTS-1:0] suppressCfg; // fault suppression per output
reg [`NUM_OUTS-1:0] levelCfg; // fault drive high per output
reg [`NUM_OUTS-1:0] invertCfg; // polarity per output
reg [`NUM_OUTS-1:0] enableCfg; // output enables

// masked update: only selected bits take the new value
function [`NUM_OUTS-1:0] maskedSet;
    input [`NUM_OUTS-1:0] old;
    input [`NUM_OUTS-1:0] sel;
    input val;
    begin
        maskedSet = val ? (old | sel) : (old & ~sel);
    end
endfunction

// configuration write ports
always @(posedge clk)
begin
    if (rst)
    begin
        suppressCfg <= `OUT_MASK_RST;
        levelCfg <= `OUT_MASK_RST;
        invertCfg <= `OUT_MASK_RST;
        enableCfg <= `OUT_MASK_RST;
    end
    else
    begin
        if (cfgSuppressWrite)
            suppressCfg <= maskedSet(suppressCfg, output_select_mask,
                fault_suppress_select); // [R1]
        // level bits only exist with extended fault handling
        if (cfgLevelWrite && (EXT_FAULT != 0))
            levelCfg <= maskedSet(levelCfg, output_select_mask,
                fault_level_high_select); // [R4] [R6]
        if (cfgInvertWrite)
            invertCfg <= maskedSet(invertCfg, output_select_mask,
                invertSelect); // [R7]
        if (cfgEnableWrite)
            enableCfg <= maskedSet(enableCfg, output_select_mask,
                enableSelect); // [R9]
    end
end

// ------------------------------------------------------------
// generator time bases
// ------------------------------------------------------------
wire [`CNT_W-1:0] genCount [0:`NUM_GENS-1]; // live counters
wire [`NUM_GENS-1:0] genPendingW; // per-generator pending flags
wire [`NUM_GENS-1:0] genApply; // one-cycle apply request

// one bit of mask per generator, any combination
assign genApply = syncUpdate ? generator_select_mask : {`NUM_GENS{1'b0}}; // [R16]

genvar g;
generate
    for (g = 0; g < `NUM_GENS; g = g + 1)
    begin : gen_tb
        pwm_gen_counter u_cnt
        (
            .clk(clk),
            .rst(rst),
            .syncReset(syncTimeBase & generator_select_mask[g]), // [R15] [R16]
            .applyUpdate(genApply[g]),
            .periodWrite(periodWrite & generator_select_mask[g]),
            .periodData(periodData),
            .count(genCount[g]),
            .activePeriod(),
            .zeroPulse(genZero[g]),
            .updatePending(genPendingW[g])
        );
    end
endgenerate

// pending flags registered for a clean status output
always @(posedge clk)
begin
    if (rst)
        genPending <= {`NUM_GENS{1'b0}};
    else
        genPending <= genPendingW;
end

// ------------------------------------------------------------
// pulse width storage and comparators
// ------------------------------------------------------------
reg [`CNT_W-1:0] widthPend [0:`NUM_OUTS-1]; // programmed widths
reg [`CNT_W-1:0] widthLive [0:`NUM_OUTS-1]; // comparator widths
reg [`NUM_OUTS-1:0] rawWave; // comparator result before polarity
wire [`NUM_OUTS-1:0] condLevel; // conditioned levels

// width read returns the programmed, not the live value
always @(posedge clk)
begin
    if (rst)
        widthReadData <= `WIDTH_RST;
    else
        widthReadData <= widthPend[output_index]; // [R13]
end

genvar o;
generate
    for (o = 0; o < `NUM_OUTS; o = o + 1)
    begin : gen_cmp
        // two outputs share each generator
        localparam integer GIDX = o / 2;

        // pending/live width and commit of the armed update
        always @(posedge clk)
        begin
            if (rst)
            begin
                widthPend[o] <= `WIDTH_RST;
                widthLive[o] <= `WIDTH_RST;
            end
            else
            begin
                if (widthWrite && output_index == o)
                    widthPend[o] <= pulse_width_count; // [R14]
                // commit at zero once the update is armed
                if (genZero[GIDX] && genPendingW[GIDX]
                    && !genApply[GIDX])
                    widthLive[o] <= widthPend[o]; // [R17]
            end
        end

        // high for width ticks after zero, before inversion
        always @(posedge clk)
        begin
            if (rst)
                rawWave[o] <= 1'b0;
            else
                rawWave[o] <= (genCount[GIDX] < widthLive[o]); // [R11] [R12]
        end

        // polarity, fault override and enable
        pwm_out_cond #(.EXT_FAULT(EXT_FAULT)) u_cond
        (
            .rawWave(rawWave[o]),
            .faultActive(faultSync),
            .suppress(suppressCfg[o]),
            .levelHigh(levelCfg[o]),
            .invert(invertCfg[o]),
            .enable(enableCfg[o]),
            .pinLevel(condLevel[o])
        );
    end
endgenerate

// ------------------------------------------------------------
// registered pin drive
// ------------------------------------------------------------

// pins come from flops; fault release restores waveform directly
always @(posedge clk)
begin
    if (rst)
        pwmPins <= `OUT_MASK_RST;
    else
        pwmPins <= condLevel; // [R1] [R19]
end

endmodule
`default_nettype wire

//--- pwm_stage_map.vh
// constants for the pwm output stage: widths, counts and reset values
`ifndef PWM_STAGE_MAP_VH
`define PWM_STAGE_MAP_VH

// ------------------------------------------------------------
// sizes
// ------------------------------------------------------------
`define NUM_GENS 4
`define NUM_OUTS 8
`define OUT_IDX_W 3
`define CNT_W 16

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define PERIOD_RST 16'h00ff
`define WIDTH_RST 16'h0000
`define OUT_MASK_RST 8'h00

`endif

//--- pwm_gen_counter.v
// one pwm time base with deferred period load at counter zero
`timescale 1ns/1ps
`default_nettype none
`include "pwm_stage_map.vh"

module pwm_gen_counter
(
    input wire clk,
    input wire rst,
    input wire syncReset,
    input wire applyUpdate,
    input wire periodWrite,
    input wire [`CNT_W-1:0] periodData,
    output reg [`CNT_W-1:0] count,
    output reg [`CNT_W-1:0] activePeriod,
    output wire zeroPulse,
    output reg updatePending
);

// ------------------------------------------------------------
// pending period and counter
// ------------------------------------------------------------
reg [`CNT_W-1:0] pendingPeriod; // last programmed period

assign zeroPulse = (count == {`CNT_W{1'b0}}); // counter-zero event

// counter runs 0..period-1, so zero repeats every period ticks
always @(posedge clk)
begin
    if (rst)
    begin
        count <= {`CNT_W{1'b0}};
        activePeriod <= `PERIOD_RST;
        pendingPeriod <= `PERIOD_RST;
        updatePending <= 1'b0;
    end
    else
    begin
        // latest write overwrites pending value
        if (periodWrite)
            pendingPeriod <= periodData; // [R14]
        // sync clear of the time base
        if (syncReset)
            count <= {`CNT_W{1'b0}}; // [R15]
        else if (count + 16'h0001 >= activePeriod)
            count <= {`CNT_W{1'b0}}; // [R18]
        else
            count <= count + 16'h0001;
        // queued values take effect at zero
        if (zeroPulse && updatePending && !applyUpdate)
        begin
            activePeriod <= pendingPeriod; // [R17]
            updatePending <= 1'b0;
        end
        else if (applyUpdate)
            updatePending <= 1'b1; // [R17]
    end
end

endmodule
`default_nettype wire

//--- pwm_out_cond.v
// one output conditioning lane: invert, fault override and enable
`timescale 1ns/1ps
`default_nettype none
`include "pwm_stage_map.vh"

module pwm_out_cond
#(
    parameter EXT_FAULT = 1
)
(
    input wire rawWave,
    input wire faultActive,
    input wire suppress,
    input wire levelHigh,
    input wire invert,
    input wire enable,
    output wire pinLevel
);

// ------------------------------------------------------------
// conditioning chain
// ------------------------------------------------------------
wire shaped; // waveform after polarity choice
wire faulted; // level chosen for fault
wire chosen; // waveform or fault level

assign shaped = invert ? ~rawWave : rawWave; // [R7] [R8]
// level high only in extended variant, otherwise low
assign faulted = (EXT_FAULT != 0) ? levelHigh : 1'b0; // [R3] [R4] [R6]
// non-suppressed outputs ignore the fault entirely
assign chosen = (faultActive && suppress) ? faulted : shaped; // [R1] [R2] [R5] [R19]
assign pinLevel = enable ? chosen : 1'b0; // [R9] [R10]

endmodule
`default_nettype wire

//--- pwm_output_stage_control_assertions.sv
// port checker for the pwm output stage
`timescale 1ns/1ps
`default_nettype none
`include "pwm_stage_map.vh"
module pwm_output_stage_control_assertions
#(
    parameter EXT_FAULT = 1
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic faultIn,
    input wire logic [7:0] output_select_mask,
    input wire logic cfgSuppressWrite,
    input wire logic fault_suppress_select,
    input wire logic cfgLevelWrite,
    input wire logic fault_level_high_select,
    input wire logic cfgEnableWrite,
    input wire logic enableSelect,
    input wire logic widthWrite,
    input wire logic [2:0] output_index,
    input wire logic [15:0] pulse_width_count,
    input wire logic [15:0] widthReadData,
    input wire logic syncTimeBase,
    input wire logic syncUpdate,
    input wire logic [3:0] generator_select_mask,
    input wire logic [3:0] genZero,
    input wire logic [3:0] genPending,
    input wire logic [7:0] pwmPins,
    input wire logic faultSeen
);
    // shadow copies of the per-output enable, suppress and level settings
    logic [7:0] en, sup, lvl;
    wire logic lvlWr = cfgLevelWrite && EXT_FAULT != 0;
    wire logic [7:0] hold = en & sup;
    wire logic [7:0] hiLv = hold & lvl;
    function automatic [7:0] upd(input [7:0] o, input w, input v);
        upd = !w ? o : v ? o | output_select_mask : o & ~output_select_mask;
    endfunction
    // track what the strobes loaded
    always_ff @(posedge clk)
    begin
        en <= rst ? 8'h00 : upd(en, cfgEnableWrite, enableSelect);
        sup <= rst ? 8'h00 : upd(sup, cfgSuppressWrite, fault_suppress_select);
        lvl <= rst ? 8'h00 : upd(lvl, lvlWr, fault_level_high_select);
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_reset_clear: assert property (disable iff (1'b0)
        rst |=> pwmPins == 8'h00 && genPending == 4'h0)
        else $error("outputs not cleared by reset");
    a_sync_zero: assert property (syncTimeBase |=>
        (genZero & $past(generator_select_mask)) == $past(generator_select_mask))
        else $error("selected counters not zeroed");
    a_pend_arm: assert property (syncUpdate |=> ##1
        (genPending & $past(generator_select_mask, 2)) ==
        $past(generator_select_mask, 2))
        else $error("update not armed");
    a_pend_apply: assert property (!syncUpdate |=> ##1
        (genPending & $past(genPending) & $past(genZero, 2)) == 4'h0)
        else $error("armed update not applied at zero");
    a_fault_sync: assert property (!$past(rst) && !$past(rst, 2) |->
        faultSeen == $past(faultIn, 2))
        else $error("fault sync delay wrong");
    a_width_read: assert property (widthWrite ##1
        (!widthWrite && $stable(output_index)) |=>
        widthReadData == $past(pulse_width_count, 2))
        else $error("width readback wrong");
    a_disabled_low: assert property ((pwmPins & ~$past(en)) == 8'h00)
        else $error("disabled output not low");
    a_fault_level: assert property ($past(faultSeen) |->
        (pwmPins & $past(hold)) == $past(hiLv))
        else $error("suppressed output level wrong");
endmodule
bind pwm_output_stage_control pwm_output_stage_control_assertions
    #(.EXT_FAULT(EXT_FAULT)) i_chk (.*);
`default_nettype wire

//--- pwm_output_stage_control_tb.sv
// self-checking bench for the pwm output stage
`timescale 1ns/1ps
`default_nettype none
module pwm_output_stage_control_tb;
    logic clk = 0, rst = 1, faultIn = 0, look = 0;
    logic cfgSuppressWrite = 0, cfgLevelWrite = 0, cfgInvertWrite = 0;
    logic cfgEnableWrite = 0, fault_suppress_select = 0, invertSelect = 0;
    logic fault_level_high_select = 0, enableSelect = 0, widthWrite = 0;
    logic periodWrite = 0, syncTimeBase = 0, syncUpdate = 0;
    logic [7:0] output_select_mask = 0, pwmPins;
    logic [2:0] output_index = 0;
    logic [15:0] pulse_width_count = 0, periodData = 0, widthReadData;
    logic [3:0] generator_select_mask = 0, genZero, genPending;
    logic faultSeen;
    logic [27:0] expQ[$], mskQ[$];
    int err_count = 0, check_count = 0, cyc = 0, i, hi, z;
    logic [31:0] r = 98743;
    pwm_output_stage_control i_dut (.*);
    always #10 clk = ~clk;
    function automatic [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic cmp(input [27:0] e, input [27:0] g);
        check_count++;
        if (g !== e)
        begin
            err_count++;
            $display("ERROR outputs exp %h got %h", e, g);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // note an expected output snapshot
    task automatic chk(input [27:0] m, input [27:0] v);
        mskQ.push_back(m);
        expQ.push_back(v);
        look = 1;
        @(negedge clk);
        look = 0;
    endtask
    // k: 0 suppress, 1 level, 2 invert, 3 enable
    task automatic cfg(input int k, input [7:0] m, input v);
        output_select_mask = m;
        {cfgEnableWrite, cfgInvertWrite, cfgLevelWrite, cfgSuppressWrite} =
            4'h1 << k;
        {enableSelect, invertSelect, fault_level_high_select,
            fault_suppress_select} = {4{v}};
        @(negedge clk);
        {cfgEnableWrite, cfgInvertWrite, cfgLevelWrite, cfgSuppressWrite} = 0;
        // let one edge pass so a following write never reuses this step
        @(negedge clk);
    endtask
    // two back-to-back width writes, then read back
    task automatic wrw(input [2:0] x, input [15:0] a, input [15:0] b);
        output_index = x;
        pulse_width_count = a;
        widthWrite = 1;
        @(negedge clk);
        pulse_width_count = b;
        @(negedge clk);
        widthWrite = 0;
        @(negedge clk);
        chk(28'h000ffff, {12'h0, b});
    endtask
    // high cycles of one pin and zeros of time base 0 over 16 cycles
    task automatic meas(input int b);
        hi = 0;
        z = 0;
        repeat (16)
        begin
            @(negedge clk);
            hi += (pwmPins[b] === 1'b1);
            z += (genZero[0] === 1'b1);
        end
    endtask
    // scoreboard: take the oldest note when a snapshot is due
    always @(posedge clk)
    begin
        cyc++;
        if (look)
            cmp(expQ.pop_front(),
                {genZero, pwmPins, widthReadData} & mskQ.pop_front());
        if (cyc == 5000)
        begin
            err_count++;
            wrap_up;
        end
    end
    initial
    begin
        repeat (5) @(negedge clk);
        rst = 0;
        chk(28'hfff0000, {4'hf, 8'h00, 16'h0});
        for (i = 0; i < 8; i++)
        begin
            r = lfsr(r);
            wrw(i[2:0], r[31:16], r[15:0]);
        end
        periodData = 16'h0008;
        generator_select_mask = 4'h1;
        periodWrite = 1;
        @(negedge clk);
        periodWrite = 0;
        wrw(3'h0, 16'h0005, 16'h0005);
        syncUpdate = 1;
        @(negedge clk);
        syncUpdate = 0;
        cfg(3, 8'hff, 1);
        cmp(1, genPending[0]);
        for (i = 0; i < 300 && genZero[0] !== 1'b1; i++)
            @(negedge clk);
        repeat (3) @(negedge clk);
        meas(0);
        cmp(10, hi);
        cmp(2, z);
        cmp(0, genPending);
        cfg(2, 8'h0d, 1);
        meas(0);
        cmp(6, hi);
        cfg(0, 8'h05, 1);
        cfg(1, 8'h09, 1);
        faultIn = 1;
        repeat (4) @(negedge clk);
        cmp(1, faultSeen);
        chk({4'h0, 8'h0d, 16'h0}, {4'h0, 8'h09, 16'h0});
        cfg(1, 8'h01, 0);
        @(negedge clk);
        chk({4'h0, 8'h01, 16'h0}, 28'h0);
        faultIn = 0;
        repeat (4) @(negedge clk);
        cmp(0, faultSeen);
        chk({4'h0, 8'h04, 16'h0}, {4'h0, 8'h04, 16'h0});
        meas(0);
        cmp(6, hi);
        cfg(3, 8'h0c, 0);
        @(negedge clk);
        chk({4'h0, 8'h0c, 16'h0}, 28'h0);
        for (i = 1; i < 16; i++)
        begin
            generator_select_mask = i[3:0];
            syncTimeBase = 1;
            @(negedge clk);
            syncTimeBase = 0;
            chk({i[3:0], 24'h0}, {i[3:0], 24'h0});
        end
        wrap_up;
    end
endmodule
`default_nettype wire
